// file: shared/rtcpt_pkg.sv
// package: register map, field positions and constants of the real time clock
package rtcpt_pkg;
  localparam int          REG_AW          = 16;
  localparam int          DATA_W          = 16;
  localparam logic [15:0] ADDR_CONTROL    = 16'hEC00;
  localparam logic [15:0] ADDR_PRE_LOW    = 16'hEC06;
  localparam logic [15:0] ADDR_PRE_HIGH   = 16'hEC08;
  localparam logic [15:0] ADDR_DIV_LOW    = 16'hEC0A;
  localparam logic [15:0] ADDR_DIV_HIGH   = 16'hEC0C;
  localparam logic [15:0] ADDR_TIME_LOW   = 16'hEC0E;
  localparam logic [15:0] ADDR_TIME_HIGH  = 16'hEC10;
  localparam logic [15:0] ADDR_ALARM_LOW  = 16'hEC12;
  localparam logic [15:0] ADDR_ALARM_HIGH = 16'hEC14;
  localparam int          BIT_TICK_FLAG   = 0;
  localparam int          BIT_TICK_EN     = 1;
  localparam int          BIT_ALARM_FLAG  = 2;
  localparam int          BIT_ALARM_EN    = 3;
  localparam int          BIT_SWITCH_OFF  = 7;
  localparam int          PREDIV_RATIO    = 64;
  localparam int          PREDIV_W        = 6;
  localparam int          DIV_W           = 20;
  localparam int          DIV_HIGH_W      = 4;
  localparam int          TIME_W          = 32;
  localparam logic [15:0] ZERO16          = 16'h0000;
endpackage

// file: core/rtcpt_prediv.sv
// fixed pre-divider giving one tick per ratio clocks
`timescale 1ns/10ps
module rtcpt_prediv
  import rtcpt_pkg::*;
#(
  parameter int RATIO = PREDIV_RATIO
) (
  input  wire logic core_clk,
  input  wire logic run,
  output logic      tick
);
  logic [PREDIV_W-1:0] cnt_r;

  // not reset by system reset; held at zero while stopped so a restart runs a full period
  always_ff @(posedge core_clk) begin
    if (!run) begin
      cnt_r <= '0;
    end else if (cnt_r == PREDIV_W'(RATIO - 1)) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + PREDIV_W'(1);
    end
  end

  assign tick = run && (cnt_r == PREDIV_W'(RATIO - 1));
endmodule // rtcpt_prediv

// file: core/rtcpt_core.sv
// real time clock: prescaler, divider, time counter, alarm and bus registers
//
// Function
// - tick equals 64 times prescale clocks
// - divider reloads each period from prescale
// - divider zero reloads and emits tick
// - prescale change loads divider immediately
// - divider read only; upper high bits zero
// - time counter increments on each tick
// - tick flag set; output gated by enable
// - alarm match sets flag; output gated
// - control bits 0,1,2,3,7 reset zero
// - switch-off stops counting, unlocks, gates oscillator in power-down
// - switch-off clear keeps everything running
// - prescale writes need switch-off set
// - time writes need switch-off set
// - time write loads; read returns count
// - alarm writes always accepted
// - system reset leaves timekeeping untouched
// - requests drive external wake-up inputs
// - all registers on 16-bit peripheral bus
`timescale 1ns/10ps
module rtcpt_core
  import rtcpt_pkg::*;
#(
  parameter int RATIO = PREDIV_RATIO
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              powerdown,
  input  wire logic              bus_sel,
  input  wire logic              bus_wr,
  input  wire logic [REG_AW-1:0] bus_addr,
  input  wire logic [DATA_W-1:0] bus_wdata,
  output logic      [DATA_W-1:0] bus_rdata,
  output logic                   tick_irq_req,
  output logic                   alarm_irq_req,
  output logic                   osc_enable
);
  // ****************************************
  // registers
  // ****************************************
  logic [DIV_W-1:0]      prescale_r;
  logic [DIV_W-1:0]      divider_r;
  logic [TIME_W-1:0]     time_r;
  logic [TIME_W-1:0]     alarm_r;
  logic                  tick_flag_r;
  logic                  tick_en_r;
  logic                  alarm_flag_r;
  logic                  alarm_en_r;
  logic                  switch_off_bit;
  logic [DATA_W-1:0]     rdata_r;
  logic                  pre_tick;
  logic                  ref_tick;
  logic                  running;
  logic                  wr_ctl;
  logic                  wr_pl;
  logic                  wr_ph;
  logic                  wr_tl;
  logic                  wr_th;
  logic                  wr_al;
  logic                  wr_ah;
  logic                  alarm_hit;
  logic                  prescale_load;
  logic [DIV_W-1:0]      prescale_nxt;

  function automatic logic hit(input logic [REG_AW-1:0] a, input logic [REG_AW-1:0] b);
    return bus_sel && bus_wr && (a == b);
  endfunction

  function automatic logic [DATA_W-1:0] upper_word(input logic [DIV_W-1:0] v);
    return DATA_W'(v[DIV_W-1:DATA_W]);
  endfunction

  assign running = !switch_off_bit;
  assign wr_ctl  = hit(bus_addr, ADDR_CONTROL);
  assign wr_pl   = hit(bus_addr, ADDR_PRE_LOW) && switch_off_bit;
  assign wr_ph   = hit(bus_addr, ADDR_PRE_HIGH) && switch_off_bit;
  assign wr_tl   = hit(bus_addr, ADDR_TIME_LOW) && switch_off_bit;
  assign wr_th   = hit(bus_addr, ADDR_TIME_HIGH) && switch_off_bit;
  assign wr_al   = hit(bus_addr, ADDR_ALARM_LOW);
  assign wr_ah   = hit(bus_addr, ADDR_ALARM_HIGH);

  // oscillator stops only in power-down with switch-off set
  assign osc_enable = !(switch_off_bit && powerdown);

  // ****************************************
  // divider chain
  // ****************************************
  rtcpt_prediv #(
    .RATIO (RATIO)
  ) u_prediv (
    .core_clk (core_clk),
    .run      (running),
    .tick     (pre_tick)
  );

  assign ref_tick = pre_tick && (divider_r == '0);

  always_comb begin
    prescale_nxt = prescale_r;
    if (wr_pl) begin
      prescale_nxt[DATA_W-1:0] = bus_wdata;
    end
    if (wr_ph) begin
      prescale_nxt[DIV_W-1:DATA_W] = bus_wdata[DIV_HIGH_W-1:0];
    end
  end
  assign prescale_load = prescale_nxt != prescale_r;

  // no reset: prescale survives system reset
  always_ff @(posedge core_clk) begin
    prescale_r <= prescale_nxt;
  end

  // divider counts down, reloads at zero; ratio 64 x prescale
  always_ff @(posedge core_clk) begin
    if (prescale_load) begin
      divider_r <= prescale_nxt;
    end else if (ref_tick) begin
      divider_r <= prescale_r - DIV_W'(1);
    end else if (pre_tick) begin
      divider_r <= divider_r - DIV_W'(1);
    end
  end

  // ****************************************
  // time counter and alarm
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (wr_tl) begin
      time_r[DATA_W-1:0] <= bus_wdata;
    end else if (wr_th) begin
      time_r[TIME_W-1:DATA_W] <= bus_wdata;
    end else if (ref_tick) begin
      time_r <= time_r + TIME_W'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (wr_al) begin
      alarm_r[DATA_W-1:0] <= bus_wdata;
    end
    if (wr_ah) begin
      alarm_r[TIME_W-1:DATA_W] <= bus_wdata;
    end
  end

  // rising edge of equality avoids re-raising each clock in the match
  logic match_r;
  always_ff @(posedge core_clk) begin
    match_r <= (time_r == alarm_r);
  end
  assign alarm_hit = (time_r == alarm_r) && !match_r;

  // ****************************************
  // control register
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tick_en_r      <= 1'b0;
      alarm_en_r     <= 1'b0;
      switch_off_bit <= 1'b0;
    end else if (wr_ctl) begin
      tick_en_r      <= bus_wdata[BIT_TICK_EN];
      alarm_en_r     <= bus_wdata[BIT_ALARM_EN];
      switch_off_bit <= bus_wdata[BIT_SWITCH_OFF];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tick_flag_r <= 1'b0;
    end else if (ref_tick) begin
      tick_flag_r <= 1'b1;
    end else if (wr_ctl) begin
      tick_flag_r <= bus_wdata[BIT_TICK_FLAG];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      alarm_flag_r <= 1'b0;
    end else if (alarm_hit) begin
      alarm_flag_r <= 1'b1;
    end else if (wr_ctl) begin
      alarm_flag_r <= bus_wdata[BIT_ALARM_FLAG];
    end
  end

  // requests route to external wake-up inputs, rising edge active
  assign tick_irq_req  = tick_flag_r && tick_en_r;
  assign alarm_irq_req = alarm_flag_r && alarm_en_r;

  // ****************************************
  // read path
  // ****************************************
  always_ff @(posedge core_clk) begin
    rdata_r <= ZERO16;
    if (bus_sel && !bus_wr) begin
      unique case (bus_addr)
        ADDR_CONTROL: begin
          rdata_r[BIT_TICK_FLAG]  <= tick_flag_r;
          rdata_r[BIT_TICK_EN]    <= tick_en_r;
          rdata_r[BIT_ALARM_FLAG] <= alarm_flag_r;
          rdata_r[BIT_ALARM_EN]   <= alarm_en_r;
          rdata_r[BIT_SWITCH_OFF] <= switch_off_bit;
        end
        ADDR_PRE_LOW:    rdata_r <= prescale_r[DATA_W-1:0];
        ADDR_PRE_HIGH:   rdata_r <= upper_word(prescale_r);
        ADDR_DIV_LOW:    rdata_r <= divider_r[DATA_W-1:0];
        ADDR_DIV_HIGH:   rdata_r <= upper_word(divider_r);
        ADDR_TIME_LOW:   rdata_r <= time_r[DATA_W-1:0];
        ADDR_TIME_HIGH:  rdata_r <= time_r[TIME_W-1:DATA_W];
        ADDR_ALARM_LOW:  rdata_r <= alarm_r[DATA_W-1:0];
        ADDR_ALARM_HIGH: rdata_r <= alarm_r[TIME_W-1:DATA_W];
        default:         rdata_r <= ZERO16;
      endcase
    end
  end
  assign bus_rdata = rdata_r;

  // ****************************************
  // checks
  // ****************************************
  a_pre_tick_single: assert property (
    @(posedge core_clk) disable iff (rst)
    pre_tick |=> !pre_tick
  ) else $error("pre-divider tick longer than one clock");
  a_divider_reload: assert property (
    @(posedge core_clk) disable iff (rst)
    prescale_load |=> divider_r == prescale_r
  ) else $error("divider not reloaded");
  a_reload_period: assert property (
    @(posedge core_clk) disable iff (rst)
    ref_tick && !prescale_load |=> divider_r == $past(prescale_r) - DIV_W'(1)
  ) else $error("divider not reloaded at zero");
  a_div_stop: assert property (
    @(posedge core_clk) disable iff (rst)
    !running && !prescale_load |=> $stable(divider_r)
  ) else $error("divider moved while stopped");
  a_high_read_zero: assert property (
    @(posedge core_clk) disable iff (rst)
    bus_sel && !bus_wr && (bus_addr == ADDR_PRE_HIGH || bus_addr == ADDR_DIV_HIGH) |=> bus_rdata[DATA_W-1:DIV_HIGH_W] == '0
  ) else $error("unused high bits not zero");
  a_prescale_lock: assert property (
    @(posedge core_clk) disable iff (rst)
    !switch_off_bit |=> $stable(prescale_r)
  ) else $error("prescale changed while locked");
  a_prescale_write: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_pl |=> prescale_r[DATA_W-1:0] == $past(bus_wdata)
  ) else $error("prescale low not written");
  a_prescale_high: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_ph |=> prescale_r[DIV_W-1:DATA_W] == $past(bus_wdata[DIV_HIGH_W-1:0])
  ) else $error("prescale high not written");

  a_time_increment: assert property (
    @(posedge core_clk) disable iff (rst)
    ref_tick && !wr_tl && !wr_th |=> time_r == $past(time_r) + TIME_W'(1)
  ) else $error("time not advanced");
  a_stop_freezes: assert property (
    @(posedge core_clk) disable iff (rst)
    switch_off_bit && !wr_tl && !wr_th |=> $stable(time_r)
  ) else $error("time moved while stopped");
  a_time_lock: assert property (
    @(posedge core_clk) disable iff (rst)
    bus_sel && bus_wr && (bus_addr == ADDR_TIME_LOW || bus_addr == ADDR_TIME_HIGH) && !switch_off_bit && !ref_tick
    |=> $stable(time_r)
  ) else $error("time written while locked");
  a_time_low_write: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_tl |=> time_r[DATA_W-1:0] == $past(bus_wdata)
  ) else $error("time low not loaded");
  a_time_high_write: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_th |=> time_r[TIME_W-1:DATA_W] == $past(bus_wdata)
  ) else $error("time high not loaded");
  a_alarm_write: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_al |=> alarm_r[DATA_W-1:0] == $past(bus_wdata)
  ) else $error("alarm low not written");
  a_alarm_high_write: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_ah |=> alarm_r[TIME_W-1:DATA_W] == $past(bus_wdata)
  ) else $error("alarm high not written");
  a_alarm_sets_flag: assert property (
    @(posedge core_clk) disable iff (rst)
    alarm_hit |=> alarm_flag_r
  ) else $error("alarm flag not set");

  a_tick_sets_flag: assert property (
    @(posedge core_clk) disable iff (rst)
    ref_tick |=> tick_flag_r
  ) else $error("tick flag not set");
  a_tick_irq_gate: assert property (
    @(posedge core_clk) disable iff (rst)
    tick_irq_req |-> tick_en_r
  ) else $error("tick irq without enable");
  a_tick_irq_on: assert property (
    @(posedge core_clk) disable iff (rst)
    tick_flag_r && tick_en_r |-> tick_irq_req
  ) else $error("tick irq missing");
  a_alarm_irq_gate: assert property (
    @(posedge core_clk) disable iff (rst)
    alarm_irq_req |-> alarm_en_r && alarm_flag_r
  ) else $error("alarm irq without enable");
  a_alarm_irq_on: assert property (
    @(posedge core_clk) disable iff (rst)
    alarm_flag_r && alarm_en_r |-> alarm_irq_req
  ) else $error("alarm irq missing");
  a_flag_set_wins: assert property (
    @(posedge core_clk) disable iff (rst)
    alarm_hit && wr_ctl |=> alarm_flag_r
  ) else $error("alarm event lost on clear");
  a_tick_clear: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_ctl && !ref_tick && !bus_wdata[BIT_TICK_FLAG] |=> !tick_flag_r
  ) else $error("tick flag not cleared");
  a_alarm_clear: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_ctl && !alarm_hit && !bus_wdata[BIT_ALARM_FLAG] |=> !alarm_flag_r
  ) else $error("alarm flag not cleared");
  a_ctl_reset: assert property (
    @(posedge core_clk)
    rst |=> !tick_en_r && !alarm_en_r && !switch_off_bit && !tick_flag_r && !alarm_flag_r
  ) else $error("control bits not reset");

  a_read_control: assert property (
    @(posedge core_clk) disable iff (rst)
    bus_sel && !bus_wr && bus_addr == ADDR_CONTROL
    |=> bus_rdata[BIT_SWITCH_OFF] == $past(switch_off_bit) && bus_rdata[BIT_TICK_FLAG] == $past(tick_flag_r)
  ) else $error("control read wrong");
  a_rdata_idle: assert property (
    @(posedge core_clk) disable iff (rst)
    !(bus_sel && !bus_wr) |=> bus_rdata == ZERO16
  ) else $error("read data not zero when idle");
  a_osc_gate: assert property (
    @(posedge core_clk)
    !switch_off_bit |-> osc_enable
  ) else $error("oscillator gated while running");
  a_osc_stop: assert property (
    @(posedge core_clk)
    switch_off_bit && powerdown |-> !osc_enable
  ) else $error("oscillator not gated in power-down");
endmodule // rtcpt_core

// file: sim/tb.sv
// testbench for the real time clock core
`timescale 1ns/10ps
module tb
  import rtcpt_pkg::*;
;
  // ************************************************************
  // clock, reset and bus signals
  // ************************************************************
  localparam int  RAT = 4;
  logic              core_clk;
  logic              rst;
  logic              powerdown;
  logic              bus_sel;
  logic              bus_wr;
  logic [REG_AW-1:0] bus_addr;
  logic [DATA_W-1:0] bus_wdata;
  logic [DATA_W-1:0] bus_rdata;
  logic              tick_irq_req;
  logic              alarm_irq_req;
  logic              osc_enable;
  logic [15:0]       v0;
  int                n_mismatch;
  int                samples_checked;

  rtcpt_core #(.RATIO(RAT)) dut (
    .core_clk      (core_clk),
    .rst           (rst),
    .powerdown     (powerdown),
    .bus_sel       (bus_sel),
    .bus_wr        (bus_wr),
    .bus_addr      (bus_addr),
    .bus_wdata     (bus_wdata),
    .bus_rdata     (bus_rdata),
    .tick_irq_req  (tick_irq_req),
    .alarm_irq_req (alarm_irq_req),
    .osc_enable    (osc_enable)
  );

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ************************************************************
  // bus tasks and compares
  // ************************************************************
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    bus_sel = 1'b1; bus_wr = 1'b1; bus_addr = a; bus_wdata = d;
    @(negedge core_clk);
    bus_sel = 1'b0;
    @(negedge core_clk);
  endtask

  task automatic wr2(input logic [15:0] a0, input logic [15:0] d0, input logic [15:0] a1, input logic [15:0] d1);
    bus_sel = 1'b1; bus_wr = 1'b1; bus_addr = a0; bus_wdata = d0;
    @(negedge core_clk);
    bus_addr = a1; bus_wdata = d1;
    @(negedge core_clk);
    bus_sel = 1'b0;
    @(negedge core_clk);
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    bus_sel = 1'b1; bus_wr = 1'b0; bus_addr = a;
    @(negedge core_clk);
    d = bus_rdata;
    bus_sel = 1'b0;
    @(negedge core_clk);
  endtask

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    cmp16({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic chk(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    cmp16(d, exp);
  endtask

  task automatic conclude();
    if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end

  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    n_mismatch = 0; samples_checked = 0;
    rst = 1'b1; powerdown = 1'b0; bus_sel = 1'b0; bus_wr = 1'b0;
    bus_addr = 16'h0000; bus_wdata = 16'h0000;
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    chk(ADDR_CONTROL, 16'h0000);
    cmp1(tick_irq_req, 1'b0);
    cmp1(osc_enable, 1'b1);
    chk(16'hEC02, 16'h0000);
    wr(ADDR_CONTROL, 16'h0080);
    wr(ADDR_PRE_HIGH, 16'hFFF5);
    wr(ADDR_PRE_LOW, 16'h0003);
    chk(ADDR_PRE_HIGH, 16'h0005);
    wr(ADDR_PRE_LOW, 16'h0002);
    chk(ADDR_DIV_HIGH, 16'h0005);
    wr(ADDR_PRE_HIGH, 16'h0000);
    wr(ADDR_PRE_LOW, 16'h0002);
    chk(ADDR_DIV_LOW, 16'h0002);
    wr(ADDR_DIV_LOW, 16'h0009);
    chk(ADDR_DIV_LOW, 16'h0002);
    chk(ADDR_DIV_HIGH, 16'h0000);
    wr(ADDR_TIME_LOW, 16'hFFFE);
    wr(ADDR_TIME_HIGH, 16'h0000);
    chk(ADDR_TIME_LOW, 16'hFFFE);
    powerdown = 1'b1;
    @(negedge core_clk);
    cmp1(osc_enable, 1'b0);
    wr(ADDR_ALARM_LOW, 16'h0001);
    wr(ADDR_ALARM_HIGH, 16'h0001);
    wr(ADDR_CONTROL, 16'h000A);
    cmp1(osc_enable, 1'b1);
    rd(ADDR_TIME_LOW, v0);
    repeat (78) @(negedge core_clk);
    chk(ADDR_TIME_LOW, v0 + 16'h0009);
    chk(ADDR_TIME_HIGH, 16'h0001);
    chk(ADDR_CONTROL, 16'h000F);
    cmp1(tick_irq_req, 1'b1);
    cmp1(alarm_irq_req, 1'b1);
    wr(ADDR_CONTROL, 16'h000B);
    chk(ADDR_CONTROL, 16'h000B);
    cmp1(alarm_irq_req, 1'b0);
    wr(ADDR_CONTROL, 16'h0009);
    cmp1(tick_irq_req, 1'b0);
    wr(ADDR_PRE_LOW, 16'h0007);
    chk(ADDR_PRE_LOW, 16'h0002);
    wr(ADDR_TIME_HIGH, 16'h00AA);
    chk(ADDR_TIME_HIGH, 16'h0001);
    wr(ADDR_ALARM_LOW, 16'h1234);
    chk(ADDR_ALARM_LOW, 16'h1234);
    wr(ADDR_CONTROL, 16'h0080);
    rd(ADDR_TIME_LOW, v0);
    repeat (40) @(negedge core_clk);
    chk(ADDR_TIME_LOW, v0);
    wr(ADDR_PRE_LOW, 16'h0100);
    wr2(ADDR_ALARM_LOW, v0, ADDR_CONTROL, 16'h0088);
    chk(ADDR_CONTROL, 16'h008C);
    cmp1(alarm_irq_req, 1'b1);
    wr(ADDR_CONTROL, 16'h0082);
    chk(ADDR_CONTROL, 16'h0082);
    rst = 1'b1;
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    chk(ADDR_CONTROL, 16'h0000);
    chk(ADDR_TIME_LOW, v0);
    chk(ADDR_PRE_LOW, 16'h0100);
    chk(ADDR_ALARM_LOW, v0);
    conclude();
  end
endmodule // tb
